// ==== core/clk_src_pkg.sv ====
// package: constants and carriers for the slow and main clock source control
package clk_src_pkg;

  typedef enum logic [1:0] {RC_FREQ_8, RC_FREQ_16, RC_FREQ_24} rc_freq_t;

  // reset values
  localparam logic     RST_FAST_RC_ENABLE = 1'b1;
  localparam rc_freq_t RST_FAST_RC_FREQ   = RC_FREQ_8;
  localparam logic     RST_XTAL_ENABLE    = 1'b0;
  localparam logic     RST_MAIN_SELECT    = 1'b0;
  localparam logic [7:0] RST_USER_TRIM    = 8'h00;

  // timing counts
  localparam int SLOW_DIV          = 8;
  localparam int MEAS_SLOW_PERIODS = 16;
  localparam int RC_SETTLE_SLOW    = 2;
  localparam int SWITCH_SLOW       = 2;

  typedef struct packed {
    logic [7:0] value_low;
    logic [7:0] value_mid;
    logic [7:0] value_high;
  } trim_set_t;

  typedef struct packed {
    logic fast_rc_stable;
    logic main_crystal_stable;
    logic main_source_switch_done;
    logic slow_source_status;
    logic measurement_ready;
  } clk_status_t;

endpackage : clk_src_pkg

// ==== core/clk_src_ctrl.sv ====
// slow and main clock source control, single clock domain
`timescale 1ns/1ps
module clk_src_ctrl #(
  parameter int TRIM_W  = 8,
  parameter int COUNT_W = 16
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // slow clock controls
  input  wire logic                         slow_crystal_select,
  input  wire logic                         slow_oscillator_bypass,
  input  wire logic                         slow_clock_in,
  // main oscillator controls
  input  wire logic                         fast_rc_enable,
  input  wire clk_src_pkg::rc_freq_t        fast_rc_frequency_select,
  input  wire logic                         main_crystal_enable,
  input  wire logic                         crystal_enable_write,
  input  wire logic [7:0]                   crystal_startup_count,
  input  wire logic                         main_crystal_bypass,
  input  wire logic                         main_source_select,
  // trimming
  input  wire clk_src_pkg::trim_set_t       factory_trim,
  input  wire clk_src_pkg::trim_set_t       user_trim_in,
  input  wire logic                         user_trim_write,
  input  wire logic                         user_trim_select_low,
  input  wire logic                         user_trim_select_mid,
  input  wire logic                         user_trim_select_high,
  // measurement and interrupt enables
  input  wire logic                         measurement_restart,
  input  wire logic                         irq_en_fast_rc,
  input  wire logic                         irq_en_crystal,
  input  wire logic                         irq_en_switch,
  // oscillator raw status
  input  wire logic                         fast_rc_ready_raw,
  input  wire logic                         crystal_ready_raw,
  // oscillator controls out
  output logic                              slow_rc_on,
  output logic                              slow_crystal_on,
  output logic                              slow_pins_to_osc,
  output logic                              slow_mux_crystal,
  output logic                              fast_rc_on,
  output clk_src_pkg::rc_freq_t             fast_rc_freq_out,
  output logic [TRIM_W-1:0]                 fast_rc_trim,
  output logic                              crystal_on,
  output logic                              crystal_pins_to_osc,
  output logic                              crystal_bypass_on,
  output logic                              main_mux_crystal,
  output logic                              main_clock_gate,
  // status and interrupt
  output clk_src_pkg::clk_status_t          status,
  output logic [COUNT_W-1:0]                measured_cycle_count,
  output logic                              irq
);

  // synchronisers: slow clock and oscillator ready lines
  logic [1:0] slow_sync_reg, rc_rdy_sync_reg, xt_rdy_sync_reg;
  logic       slow_prev_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      slow_sync_reg   <= 2'b00;
      rc_rdy_sync_reg <= 2'b00;
      xt_rdy_sync_reg <= 2'b00;
      slow_prev_reg   <= 1'b0;
    end
    else
    begin
      slow_sync_reg   <= {slow_sync_reg[0], slow_clock_in};
      rc_rdy_sync_reg <= {rc_rdy_sync_reg[0], fast_rc_ready_raw};
      xt_rdy_sync_reg <= {xt_rdy_sync_reg[0], crystal_ready_raw};
      slow_prev_reg   <= slow_sync_reg[1];
    end

  // slow clock edge events
  wire slow_rise = slow_sync_reg[1] & ~slow_prev_reg;
  wire slow_fall = ~slow_sync_reg[1] & slow_prev_reg;

  // slow source sequence
  typedef enum logic [2:0] {SL_RC, SL_PINS, SL_XTAL_ON, SL_SWITCH, SL_DONE} slow_state_t;
  slow_state_t slow_state_reg, slow_state_next;
  always_comb
  begin
    slow_state_next = slow_state_reg;
    unique case (slow_state_reg)
      SL_RC:      if (slow_crystal_select) slow_state_next = SL_PINS;
      SL_PINS:    slow_state_next = SL_XTAL_ON;
      SL_XTAL_ON: if (slow_rise) slow_state_next = SL_SWITCH;
      SL_SWITCH:  if (slow_fall) slow_state_next = SL_DONE;
      // no way back except reset
      SL_DONE:    slow_state_next = SL_DONE;
    endcase
  end

  // power-up state runs slow RC only
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) slow_state_reg <= SL_RC;
    else     slow_state_reg <= slow_state_next;

  // slow oscillator outputs from the sequence state
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      slow_rc_on       <= 1'b1;
      slow_crystal_on  <= 1'b0;
      slow_pins_to_osc <= 1'b0;
      slow_mux_crystal <= 1'b0;
    end
    else
    begin
      slow_rc_on       <= (slow_state_next != SL_DONE);
      slow_crystal_on  <= (slow_state_next inside {SL_XTAL_ON, SL_SWITCH, SL_DONE})
                          & ~slow_oscillator_bypass;
      // pins stay inputs until the sequence
      slow_pins_to_osc <= (slow_state_next != SL_RC);
      slow_mux_crystal <= (slow_state_next == SL_DONE);
    end

  // slow clock divided by 8 tick for the start-up counter
  logic [2:0] div_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)            div_reg <= 3'h0;
    else if (slow_rise) div_reg <= div_reg + 3'h1;
  wire div_tick = slow_rise & (div_reg == 3'(clk_src_pkg::SLOW_DIV - 1));

  // main crystal start-up counter
  logic [7:0] xt_count_reg;
  logic       xt_counting_reg, xt_stable_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      xt_count_reg    <= 8'h00;
      xt_counting_reg <= 1'b0;
      xt_stable_reg   <= 1'b0;
    end
    else if (!main_crystal_enable)
    begin
      xt_counting_reg <= 1'b0;
      xt_stable_reg   <= 1'b0;
    end
    else if (crystal_enable_write)
    begin
      xt_count_reg    <= crystal_startup_count;
      xt_counting_reg <= 1'b1;
      xt_stable_reg   <= 1'b0;
    end
    else if (xt_counting_reg && xt_count_reg == 8'h00)
    begin
      xt_counting_reg <= 1'b0;
      xt_stable_reg   <= xt_rdy_sync_reg[1] | main_crystal_bypass;
    end
    else if (xt_counting_reg && div_tick)
      xt_count_reg <= xt_count_reg - 8'h01;

  // fast RC settle after enable or frequency change
  clk_src_pkg::rc_freq_t freq_prev_reg;
  logic [1:0] rc_settle_reg;
  logic       rc_stable_reg;
  wire freq_change = (fast_rc_frequency_select != freq_prev_reg);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      freq_prev_reg <= clk_src_pkg::RST_FAST_RC_FREQ;
      rc_settle_reg <= 2'(clk_src_pkg::RC_SETTLE_SLOW);
      rc_stable_reg <= 1'b0;
    end
    else
    begin
      freq_prev_reg <= fast_rc_frequency_select;
      if (!fast_rc_enable)
      begin
        rc_stable_reg <= 1'b0;
        rc_settle_reg <= 2'(clk_src_pkg::RC_SETTLE_SLOW);
      end
      else if (freq_change)
      begin
        rc_stable_reg <= 1'b0;
        rc_settle_reg <= 2'(clk_src_pkg::RC_SETTLE_SLOW);
      end
      else if (rc_settle_reg != 2'h0)
      begin
        if (slow_rise) rc_settle_reg <= rc_settle_reg - 2'h1;
      end
      else rc_stable_reg <= rc_rdy_sync_reg[1];
    end

  // glitch-free main source switch, completes on slow edges
  logic       sel_prev_reg, sw_done_reg;
  logic [1:0] sw_wait_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      sel_prev_reg     <= clk_src_pkg::RST_MAIN_SELECT;
      sw_wait_reg      <= 2'h0;
      sw_done_reg      <= 1'b1;
      main_mux_crystal <= clk_src_pkg::RST_MAIN_SELECT;
    end
    else
    begin
      sel_prev_reg <= main_source_select;
      if (main_source_select != sel_prev_reg)
      begin
        sw_done_reg <= 1'b0;
        sw_wait_reg <= 2'(clk_src_pkg::SWITCH_SLOW);
      end
      else if (!sw_done_reg && slow_rise)
      begin
        if (sw_wait_reg == 2'h1)
        begin
          main_mux_crystal <= main_source_select;
          sw_done_reg      <= main_source_select ? xt_stable_reg : rc_stable_reg;
        end
        sw_wait_reg <= sw_wait_reg - 2'h1;
      end
    end

  // user trim storage, back to defaults on every reset
  clk_src_pkg::trim_set_t user_trim_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)                  user_trim_reg <= {3{clk_src_pkg::RST_USER_TRIM}};
    else if (user_trim_write) user_trim_reg <= user_trim_in;

  wire [7:0] trim_low  = user_trim_select_low  ? user_trim_reg.value_low  : factory_trim.value_low;
  wire [7:0] trim_mid  = user_trim_select_mid  ? user_trim_reg.value_mid  : factory_trim.value_mid;
  wire [7:0] trim_high = user_trim_select_high ? user_trim_reg.value_high : factory_trim.value_high;
  wire [7:0] trim_sel  = (fast_rc_frequency_select == clk_src_pkg::RC_FREQ_24) ? trim_high :
                         (fast_rc_frequency_select == clk_src_pkg::RC_FREQ_16) ? trim_mid  :
                         trim_low;

  // frequency measurement from a slow rise to the 16th slow fall
  logic [4:0]         meas_slow_reg;
  logic               meas_arm_reg, meas_run_reg, meas_rdy_reg;
  logic [COUNT_W-1:0] meas_cnt_reg;
  wire meas_start = measurement_restart | (main_source_select != sel_prev_reg)
                  | (rc_rdy_sync_reg[1] & ~rc_stable_reg & fast_rc_enable & ~freq_change)
                  | (crystal_enable_write & main_crystal_enable);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      meas_arm_reg  <= 1'b0;
      meas_run_reg  <= 1'b0;
      meas_rdy_reg  <= 1'b0;
      meas_slow_reg <= 5'h00;
      meas_cnt_reg  <= '0;
    end
    else if (meas_start)
    begin
      meas_arm_reg <= 1'b1;
      meas_run_reg <= 1'b0;
      meas_rdy_reg <= 1'b0;
    end
    else if (meas_arm_reg && slow_rise)
    begin
      meas_arm_reg  <= 1'b0;
      meas_run_reg  <= 1'b1;
      meas_slow_reg <= 5'h00;
      meas_cnt_reg  <= '0;
    end
    else if (meas_run_reg)
    begin
      meas_cnt_reg <= meas_cnt_reg + 1'b1;
      if (slow_fall)
      begin
        meas_slow_reg <= meas_slow_reg + 5'h01;
        if (meas_slow_reg == 5'(clk_src_pkg::MEAS_SLOW_PERIODS - 1))
        begin
          meas_run_reg <= 1'b0;
          meas_rdy_reg <= 1'b1;
        end
      end
    end

  // registered oscillator controls and status
  logic rc_stable_d_reg, xt_stable_d_reg, sw_done_d_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      // fast RC on, 8 MHz, selected
      fast_rc_on           <= clk_src_pkg::RST_FAST_RC_ENABLE;
      fast_rc_freq_out     <= clk_src_pkg::RST_FAST_RC_FREQ;
      fast_rc_trim         <= '0;
      crystal_on           <= clk_src_pkg::RST_XTAL_ENABLE;
      crystal_pins_to_osc  <= 1'b0;
      crystal_bypass_on    <= 1'b0;
      main_clock_gate      <= 1'b0;
      status               <= '0;
      measured_cycle_count <= '0;
      irq                  <= 1'b0;
      rc_stable_d_reg      <= 1'b0;
      xt_stable_d_reg      <= 1'b0;
      sw_done_d_reg        <= 1'b1;
    end
    else
    begin
      fast_rc_on           <= fast_rc_enable;
      fast_rc_freq_out     <= fast_rc_frequency_select;
      fast_rc_trim         <= TRIM_W'(trim_sel);
      crystal_on           <= main_crystal_enable & ~main_crystal_bypass;
      crystal_pins_to_osc  <= main_crystal_enable | main_crystal_bypass;
      crystal_bypass_on    <= main_crystal_bypass;
      main_clock_gate      <= main_mux_crystal ? xt_stable_reg : rc_stable_reg;
      // slow status taken from the slow source mux select
      status.slow_source_status      <= slow_mux_crystal;
      status.fast_rc_stable          <= rc_stable_reg;
      status.main_crystal_stable     <= xt_stable_reg;
      status.main_source_switch_done <= sw_done_reg;
      status.measurement_ready       <= meas_rdy_reg;
      measured_cycle_count <= meas_rdy_reg ? meas_cnt_reg : '0;
      rc_stable_d_reg      <= rc_stable_reg;
      xt_stable_d_reg      <= xt_stable_reg;
      sw_done_d_reg        <= sw_done_reg;
      irq <= (irq_en_fast_rc & rc_stable_reg & ~rc_stable_d_reg)
           | (irq_en_crystal & xt_stable_reg & ~xt_stable_d_reg)
           | (irq_en_switch  & sw_done_reg   & ~sw_done_d_reg);
    end

endmodule : clk_src_ctrl

// ==== bench/clk_src_ctrl_assertions.sv ====
// checker: port-level properties of the clock source control
`timescale 1ns/1ps
module clk_src_ctrl_chk #(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst,
  // watched controls
  input wire logic                     fast_rc_enable,
  input wire clk_src_pkg::rc_freq_t    fast_rc_frequency_select,
  input wire logic                     main_crystal_enable,
  input wire logic                     crystal_enable_write,
  input wire logic                     irq_en_fast_rc,
  // watched outputs
  input wire logic                     slow_rc_on,
  input wire logic                     slow_crystal_on,
  input wire logic                     slow_pins_to_osc,
  input wire logic                     slow_mux_crystal,
  input wire logic                     crystal_pins_to_osc,
  input wire clk_src_pkg::clk_status_t status,
  input wire logic [COUNT_W-1:0]       measured_cycle_count,
  input wire logic                     irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // slow source switch
  slow_sticky_a: assert property (slow_mux_crystal |=> slow_mux_crystal)
    else $error("slow crystal selection dropped");
  slow_order_a: assert property ($rose(slow_crystal_on) |-> slow_pins_to_osc)
    else $error("slow crystal enabled before pins handed over");
  rc_off_a: assert property (!slow_rc_on |-> slow_mux_crystal && slow_pins_to_osc)
    else $error("slow rc stopped before switch");
  slow_status_a: assert property (status.slow_source_status |-> slow_mux_crystal)
    else $error("slow status set without crystal source");

  // fast rc and crystal flags, interrupt and measurement count
  rc_disable_a: assert property (!fast_rc_enable [*3] |-> !status.fast_rc_stable)
    else $error("fast rc stable while disabled");
  rc_retune_a: assert property (fast_rc_enable && $changed(fast_rc_frequency_select)
    |-> ##[1:3] !status.fast_rc_stable)
    else $error("retune did not clear fast rc stable");
  xtal_off_a: assert property (!main_crystal_enable [*3] |-> !status.main_crystal_stable)
    else $error("crystal stable while disabled");
  xtal_load_a: assert property (crystal_enable_write && main_crystal_enable
    |-> ##[1:3] (crystal_pins_to_osc && !status.main_crystal_stable))
    else $error("crystal start did not clear stable or take pins");
  irq_rc_a: assert property ($rose(status.fast_rc_stable) && irq_en_fast_rc
    |-> irq || $past(irq))
    else $error("no interrupt on fast rc stable");
  meas_zero_a: assert property (!status.measurement_ready
    |-> measured_cycle_count == '0)
    else $error("count shown while not ready");

  // main scenarios reached
  cover property (status.main_crystal_stable);
  cover property (status.measurement_ready);
  cover property (slow_mux_crystal && !slow_rc_on);
endmodule : clk_src_ctrl_chk

bind clk_src_ctrl clk_src_ctrl_chk #(.COUNT_W(COUNT_W)) chk_u (.sys_clk, .rst,
  .fast_rc_enable, .fast_rc_frequency_select, .main_crystal_enable, .crystal_enable_write,
  .irq_en_fast_rc, .slow_rc_on, .slow_crystal_on, .slow_pins_to_osc, .slow_mux_crystal,
  .crystal_pins_to_osc, .status, .measured_cycle_count, .irq);

// ==== bench/osc_model.sv ====
// model: oscillators and slow clock source facing the control block
`timescale 1ns/1ps
module osc_model #(
  parameter int SLOW_HALF = 20,
  parameter int SETTLE    = 6
) (
  // clock
  input  wire logic                  sys_clk,
  // oscillator controls from the block
  input  wire logic                  fast_rc_on,
  input  wire clk_src_pkg::rc_freq_t fast_rc_freq_out,
  input  wire logic                  crystal_on,
  // slow clock and ready flags back
  output logic                       slow_clock_in,
  output logic                       fast_rc_ready_raw,
  output logic                       crystal_ready_raw
);
  int                    slow_cnt  = 0;
  int                    rc_cnt    = 0;
  int                    xt_cnt    = 0;
  clk_src_pkg::rc_freq_t freq_seen = clk_src_pkg::RC_FREQ_8;
  initial slow_clock_in = 1'h0;

  // free-running slow clock, never stops
  always @(posedge sys_clk)
  begin
    slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == SLOW_HALF - 1)
      slow_clock_in <= ~slow_clock_in;
  end

  // oscillator settle
  // ready drops on a stop or a retune, returns after settling
  always @(posedge sys_clk)
  begin
    freq_seen <= fast_rc_freq_out;
    rc_cnt    <= (!fast_rc_on || freq_seen != fast_rc_freq_out) ? 0 : rc_cnt + 1;
    xt_cnt    <= crystal_on ? xt_cnt + 1 : 0;
  end
  assign fast_rc_ready_raw = rc_cnt >= SETTLE;
  assign crystal_ready_raw = xt_cnt >= SETTLE;
endmodule : osc_model

// ==== bench/tb.sv ====
// testbench: self-checking run of the clock source control
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    clk_src_pkg::rc_freq_t freq;
    logic [2:0]            sel;
    logic [7:0]            trim;
  } row_t;
  logic sys_clk, rst, slow_crystal_select, slow_oscillator_bypass, fast_rc_enable;
  logic main_crystal_enable, crystal_enable_write, main_crystal_bypass, main_source_select;
  logic user_trim_write, user_trim_select_low, user_trim_select_mid, user_trim_select_high;
  logic measurement_restart, irq_en_fast_rc, irq_en_crystal, irq_en_switch, irq;
  logic slow_clock_in, fast_rc_ready_raw, crystal_ready_raw, slow_rc_on, slow_crystal_on;
  logic slow_pins_to_osc, slow_mux_crystal, fast_rc_on, crystal_on, crystal_pins_to_osc;
  logic                     main_mux_crystal, crystal_bypass_on, main_clock_gate;
  logic [7:0]               crystal_startup_count, fast_rc_trim;
  logic [15:0]              measured_cycle_count;
  clk_src_pkg::rc_freq_t    fast_rc_frequency_select, fast_rc_freq_out;
  clk_src_pkg::trim_set_t   factory_trim, user_trim_in;
  clk_src_pkg::clk_status_t status;
  int                       checked = 0;
  int                       err_total = 0;
  int                       irq_cnt = 0;
  wire logic [6:0]          watch = {status, main_mux_crystal, slow_mux_crystal};
  row_t                     rows [6] = '{
    '{clk_src_pkg::RC_FREQ_8, 3'h0, 8'h1A}, '{clk_src_pkg::RC_FREQ_8, 3'h4, 8'h4D},
    '{clk_src_pkg::RC_FREQ_16, 3'h0, 8'h2B}, '{clk_src_pkg::RC_FREQ_16, 3'h2, 8'h5E},
    '{clk_src_pkg::RC_FREQ_24, 3'h2, 8'h3C}, '{clk_src_pkg::RC_FREQ_24, 3'h1, 8'h6F}};

  clk_src_ctrl dut_u (.*);
  osc_model osc_u (.*);

  // clock and interrupt tally
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (irq === 1'h1)
      irq_cnt++;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic wait_bit(input int b, input logic v);
    int i;
    i = 0;
    while (watch[b] !== v && i < 4000)
    begin
      tick(1);
      i++;
    end
    if (i == 4000)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: wait on bit %0d timed out", $time, b);
      finish_test();
    end
  endtask : wait_bit

  // main sequence
  initial
  begin
    int k;
    {slow_crystal_select, slow_oscillator_bypass, main_crystal_enable} = 3'h0;
    {crystal_enable_write, main_crystal_bypass, main_source_select} = 3'h0;
    {user_trim_write, measurement_restart} = 2'h0;
    {user_trim_select_low, user_trim_select_mid, user_trim_select_high} = 3'h0;
    {irq_en_fast_rc, irq_en_crystal, irq_en_switch} = 3'h7;
    fast_rc_enable = 1'h1;
    fast_rc_frequency_select = clk_src_pkg::RC_FREQ_8;
    crystal_startup_count = 8'h02;
    factory_trim = 24'h1A2B3C;
    user_trim_in = 24'h4D5E6F;
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    check({fast_rc_on, fast_rc_freq_out}, {1'h1, clk_src_pkg::RST_FAST_RC_FREQ});
    check({crystal_on, main_mux_crystal, crystal_pins_to_osc}, 3'h0);
    check({slow_rc_on, slow_crystal_on, slow_mux_crystal, slow_pins_to_osc}, 4'h8);
    $display("test done: reset values");
    user_trim_write = 1'h1;
    tick(1);
    user_trim_write = 1'h0;
    wait_bit(6, 1'h1);
    foreach (rows[i])
    begin
      if (rows[i].freq != fast_rc_frequency_select)
      begin
        fast_rc_frequency_select = rows[i].freq;
        tick(3);
        check({status.fast_rc_stable, main_clock_gate}, 2'h0);
        wait_bit(6, 1'h1);
      end
      {user_trim_select_low, user_trim_select_mid, user_trim_select_high} = rows[i].sel;
      tick(4);
      check({main_clock_gate, fast_rc_trim}, {1'h1, rows[i].trim});
    end
    $display("test done: trim rows");
    main_crystal_enable = 1'h1;
    crystal_enable_write = 1'h1;
    tick(1);
    crystal_enable_write = 1'h0;
    k = irq_cnt;
    tick(250);
    check({crystal_pins_to_osc, status.main_crystal_stable}, 2'h2);
    wait_bit(5, 1'h1);
    tick(2);
    check(irq_cnt > k, 1'h1);
    $display("test done: crystal start");
    // both oscillators stay on while switching
    main_source_select = 1'h1;
    k = irq_cnt;
    wait_bit(1, 1'h1);
    tick(3);
    check({status.main_source_switch_done, irq_cnt > k}, 2'h3);
    fast_rc_enable = 1'h0;
    tick(4);
    check(status.fast_rc_stable, 1'h0);
    fast_rc_enable = 1'h1;
    k = irq_cnt;
    wait_bit(6, 1'h1);
    tick(2);
    check(irq_cnt > k, 1'h1);
    main_source_select = 1'h0;
    wait_bit(1, 1'h0);
    tick(4);
    main_crystal_enable = 1'h0;
    tick(4);
    check({crystal_on, status.main_crystal_stable}, 2'h0);
    // external clock present, bypass on, then crystal off
    {main_crystal_enable, crystal_enable_write} = 2'h3;
    tick(1);
    {crystal_enable_write, main_crystal_bypass} = 2'h1;
    tick(1);
    main_crystal_enable = 1'h0;
    tick(4);
    check({crystal_bypass_on, crystal_pins_to_osc, crystal_on}, 3'h6);
    $display("test done: main source switch");
    slow_oscillator_bypass = 1'h1;
    tick(1);
    slow_crystal_select = 1'h1;
    tick(4);
    check({slow_pins_to_osc, slow_mux_crystal}, 2'h2);
    wait_bit(3, 1'h1);
    check({slow_rc_on, slow_mux_crystal}, 2'h1);
    slow_crystal_select = 1'h0;
    tick(200);
    check({slow_rc_on, slow_mux_crystal}, 2'h1);
    $display("test done: slow crystal switch");
    measurement_restart = 1'h1;
    tick(1);
    measurement_restart = 1'h0;
    tick(3);
    check(status.measurement_ready, 1'h0);
    wait_bit(2, 1'h1);
    // slow rise to the 16th slow fall, 40 system clocks a period, within one period
    check(measured_cycle_count > 16'h0258 && measured_cycle_count <= 16'h0280, 1'h1);
    $display("test done: measurement");
    fast_rc_frequency_select = clk_src_pkg::RC_FREQ_8;
    {user_trim_select_low, user_trim_select_mid, user_trim_select_high} = 3'h4;
    tick(4);
    {irq_en_fast_rc, irq_en_crystal, irq_en_switch} = 3'h0;
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    tick(4);
    check(fast_rc_trim, clk_src_pkg::RST_USER_TRIM);
    // masked: no interrupt when stable rises
    k = irq_cnt;
    wait_bit(6, 1'h1);
    tick(2);
    check(irq_cnt == k, 1'h1);
    // crystal amplifier runs when not bypassed
    slow_oscillator_bypass = 1'h0;
    slow_crystal_select = 1'h1;
    tick(4);
    check({slow_pins_to_osc, slow_crystal_on, slow_mux_crystal}, 3'h6);
    wait_bit(3, 1'h1);
    check({slow_rc_on, slow_crystal_on, slow_mux_crystal}, 3'h3);
    $display("test done: trim after reset");
    finish_test();
  end
endmodule : tb
